/* design/gkis_pkg.sv */
//------------------------------------------------------------------
// gkis_pkg: constants for the pin interrupt selector
//------------------------------------------------------------------
//------------------------------------------------------------------
package gkis_pkg;

    // printed register offsets, kept as register indices
    localparam logic [31:0] GKIS_BASE = 32'h50001400;
    localparam logic [31:0] GKIS_OFF_SEL0 = 32'h50001400;
    localparam logic [31:0] GKIS_OFF_SEL1 = 32'h50001402;
    localparam logic [31:0] GKIS_OFF_SEL2 = 32'h50001404;
    localparam logic [31:0] GKIS_OFF_SEL3 = 32'h50001406;
    localparam logic [31:0] GKIS_OFF_SEL4 = 32'h50001408;
    localparam logic [31:0] GKIS_OFF_FILT = 32'h5000140C;
    localparam logic [31:0] GKIS_OFF_CLR = 32'h5000140E;
    localparam logic [31:0] GKIS_OFF_POL = 32'h50001410;
    localparam logic [31:0] GKIS_OFF_KEYLO = 32'h50001412;
    localparam logic [31:0] GKIS_OFF_KEYMID = 32'h50001414;
    localparam logic [31:0] GKIS_OFF_KEYHI = 32'h50001416;

    // apb byte address is four times the index above the base
    localparam int GKIS_AW = 8;
    localparam logic [GKIS_AW-1:0] GKIS_A_SEL0 = 8'(4 * (GKIS_OFF_SEL0 - GKIS_BASE));
    localparam logic [GKIS_AW-1:0] GKIS_A_FILT = 8'(4 * (GKIS_OFF_FILT - GKIS_BASE));
    localparam logic [GKIS_AW-1:0] GKIS_A_CLR = 8'(4 * (GKIS_OFF_CLR - GKIS_BASE));
    localparam logic [GKIS_AW-1:0] GKIS_A_POL = 8'(4 * (GKIS_OFF_POL - GKIS_BASE));
    localparam logic [GKIS_AW-1:0] GKIS_A_KEYLO = 8'(4 * (GKIS_OFF_KEYLO - GKIS_BASE));
    localparam logic [GKIS_AW-1:0] GKIS_A_KEYMID = 8'(4 * (GKIS_OFF_KEYMID - GKIS_BASE));
    localparam logic [GKIS_AW-1:0] GKIS_A_KEYHI = 8'(4 * (GKIS_OFF_KEYHI - GKIS_BASE));
    localparam logic [GKIS_AW-1:0] GKIS_A_STAT = 8'h60;
    localparam logic [GKIS_AW-1:0] GKIS_A_MASK = 8'h64;
    localparam logic [GKIS_AW-1:0] GKIS_A_STEP = 8'h08;

    // field layout
    localparam int GKIS_NCH = 5;
    localparam int GKIS_NSRC = 6;
    localparam int GKIS_KEY = 5;
    localparam int GKIS_CODE_W = 6;
    localparam int GKIS_FILT_ON_LSB = 8;
    localparam int GKIS_FILT_KEY_BIT = 13;
    localparam int GKIS_POL_LSB = 0;
    localparam int GKIS_WAIT_LSB = 8;
    localparam int GKIS_KEY_LEVEL_BIT = 14;
    localparam logic [15:0] GKIS_SEL_MASK = 16'h003F;
    localparam logic [15:0] GKIS_FILT_MASK = 16'h3F3F;
    localparam logic [15:0] GKIS_POL_MASK = 16'h1F1F;
    localparam logic [15:0] GKIS_KEYHI_MASK = 16'h00FF;
    localparam logic [15:0] GKIS_SRC_MASK = 16'h003F;

    // reset values
    localparam logic [15:0] GKIS_RST16 = 16'h0000;
    localparam logic [5:0] GKIS_RST6 = 6'h00;

    // time base: one millisecond at a 40 MHz clock
    localparam int GKIS_CLK_NS = 25;
    localparam int GKIS_MS_NS = 1000000;
    localparam int GKIS_MS_CYCLES = GKIS_MS_NS / GKIS_CLK_NS;

endpackage

/* design/gkis_top.sv */
`timescale 1ns/100ps
`default_nettype none
module gkis_top
    import gkis_pkg::*;
#(
    parameter int TICK_CYCLES = GKIS_MS_CYCLES
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [GKIS_AW-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [7:0] port0_pins,
    input wire logic [5:0] port1_pins,
    input wire logic [9:0] port2_pins,
    input wire logic [7:0] port3_pins,
    output logic pin_irq_chan0,
    output logic pin_irq_chan1,
    output logic pin_irq_chan2,
    output logic pin_irq_chan3,
    output logic pin_irq_chan4,
    output logic keypad_irq_line,
    output logic irq
);

    //------------------------------------------------------------------
    // helpers
    //------------------------------------------------------------------

    // codes 1..31 name a pin; zero and codes above 31 name none
    function automatic logic code_valid(input logic [GKIS_CODE_W-1:0] code);
        return code != 6'h00 && code < 6'h20;
    endfunction

    // code c (1..31) maps to bit c-1 of the flattened pin vector
    function automatic logic pick_pin(input logic [GKIS_CODE_W-1:0] code,
                                      input logic [31:0] pins);
        logic hit;
        hit = 1'b0;
        if (code_valid(code)) begin
            hit = pins[5'(code - 6'h01)];
        end
        return hit;
    endfunction

    // address match helper for the apb decode
    function automatic logic at(input logic [GKIS_AW-1:0] a,
                                input logic [GKIS_AW-1:0] b);
        return a == b;
    endfunction

    //------------------------------------------------------------------
    // registers
    //------------------------------------------------------------------
    logic [GKIS_CODE_W-1:0] pin_code_ff [GKIS_NCH];
    logic [15:0] filt_ff;
    logic [15:0] pol_ff;
    logic [15:0] keylo_ff;
    logic [15:0] keymid_ff;
    logic [15:0] keyhi_ff;
    logic [GKIS_NSRC-1:0] stat_ff;
    logic [GKIS_NSRC-1:0] mask_ff;
    logic [GKIS_NSRC-1:0] pend_ff;
    logic [GKIS_NSRC-1:0] block_ff;
    logic [31:0] rdata_ff;
    logic ready_ff;
    logic err_ff;
    logic irq_ff;
    logic [15:0] tick_cnt_ff;
    logic tick_ff;

    //------------------------------------------------------------------
    // apb decode
    //------------------------------------------------------------------
    wire setup_ph = psel & ~penable;
    wire access_done = psel & penable & ready_ff;
    wire wr_go = access_done & pwrite;
    wire rd_go = access_done & ~pwrite;
    wire [15:0] wdat = pwdata[15:0];

    wire [GKIS_NCH-1:0] hit_sel;
    wire hit_filt = at(paddr, GKIS_A_FILT);
    wire hit_clr = at(paddr, GKIS_A_CLR);
    wire hit_pol = at(paddr, GKIS_A_POL);
    wire hit_keylo = at(paddr, GKIS_A_KEYLO);
    wire hit_keymid = at(paddr, GKIS_A_KEYMID);
    wire hit_keyhi = at(paddr, GKIS_A_KEYHI);
    wire hit_stat = at(paddr, GKIS_A_STAT);
    wire hit_mask = at(paddr, GKIS_A_MASK);
    wire hit_any = (|hit_sel) | hit_filt | hit_clr | hit_pol | hit_keylo
                   | hit_keymid | hit_keyhi | hit_stat | hit_mask;

    genvar g;
    generate
        for (g = 0; g < GKIS_NCH; g++) begin : g_hit
            assign hit_sel[g] = at(paddr, GKIS_A_SEL0 + 8'(g) * GKIS_A_STEP);
        end
    endgenerate

    // clear strobe: only ones written to the clear register act
    wire [GKIS_NSRC-1:0] clr_req = (wr_go & hit_clr) ? wdat[GKIS_NSRC-1:0]
                                                     : '0;
    // only the status bits handed out are cleared, so a late event survives
    wire [GKIS_NSRC-1:0] stat_rdclr = (rd_go & hit_stat) ? rdata_ff[GKIS_NSRC-1:0] : '0;

    //------------------------------------------------------------------
    // read mux
    //------------------------------------------------------------------
    logic [15:0] rmux;
    always_comb begin
        rmux = 16'h0000;
        for (int i = 0; i < GKIS_NCH; i++) begin
            if (hit_sel[i]) begin
                rmux = {10'h000, pin_code_ff[i]};
            end
        end
        if (hit_filt) begin
            rmux = filt_ff;
        end
        if (hit_clr) begin
            rmux = 16'h0000;
        end
        if (hit_pol) begin
            rmux = pol_ff;
        end
        if (hit_keylo) begin
            rmux = keylo_ff;
        end
        if (hit_keymid) begin
            rmux = keymid_ff;
        end
        if (hit_keyhi) begin
            rmux = keyhi_ff;
        end
        if (hit_stat) begin
            rmux = {10'h000, stat_ff};
        end
        if (hit_mask) begin
            rmux = {10'h000, mask_ff};
        end
    end

    // answer is prepared in setup, so the access phase ends at once
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rdata_ff <= 32'h00000000;
            ready_ff <= 1'b0;
            err_ff <= 1'b0;
        end else begin
            rdata_ff <= setup_ph ? {16'h0000, rmux} : 32'h00000000;
            ready_ff <= setup_ph;
            err_ff <= setup_ph & ~hit_any;
        end
    end

    //------------------------------------------------------------------
    // software writable registers
    //------------------------------------------------------------------
    generate
        for (g = 0; g < GKIS_NCH; g++) begin : g_code
            // one selection code per channel
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    pin_code_ff[g] <= GKIS_RST6;
                end else if (wr_go && hit_sel[g]) begin
                    pin_code_ff[g] <= wdat[GKIS_CODE_W-1:0];
                end
            end
        end
    endgenerate

    // reserved bits are masked off on write, except in the key low and key mid registers, which keep all 16 bits
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            filt_ff <= GKIS_RST16;
            pol_ff <= GKIS_RST16;
            keylo_ff <= GKIS_RST16;
            keymid_ff <= GKIS_RST16;
            keyhi_ff <= GKIS_RST16;
            mask_ff <= GKIS_RST6;
        end else if (wr_go) begin
            if (hit_filt) filt_ff <= wdat & GKIS_FILT_MASK;
            if (hit_pol) pol_ff <= wdat & GKIS_POL_MASK;
            if (hit_keylo) keylo_ff <= wdat;
            if (hit_keymid) keymid_ff <= wdat;
            if (hit_keyhi) keyhi_ff <= wdat & GKIS_KEYHI_MASK;
            if (hit_mask) mask_ff <= wdat[GKIS_NSRC-1:0];
        end
    end

    //------------------------------------------------------------------
    // millisecond time base
    //------------------------------------------------------------------
    wire tick_wrap = tick_cnt_ff == 16'(TICK_CYCLES - 1);

    // one-cycle enable pulse every millisecond
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tick_cnt_ff <= 16'h0000;
            tick_ff <= 1'b0;
        end else begin
            tick_cnt_ff <= tick_wrap ? 16'h0000 : tick_cnt_ff + 16'h0001;
            tick_ff <= tick_wrap;
        end
    end

    //------------------------------------------------------------------
    // source selection
    //------------------------------------------------------------------
    wire [31:0] pins_flat = {port3_pins, port2_pins, port1_pins, port0_pins};
    wire [31:0] key_en = {keyhi_ff[7:0], keymid_ff, keylo_ff[7:0]};
    wire [31:0] key_pins = {port3_pins, port1_pins, port2_pins, port0_pins};
    wire key_low = keylo_ff[GKIS_KEY_LEVEL_BIT];
    wire [GKIS_NSRC-1:0] active;
    wire [GKIS_NSRC-1:0] filt_on;
    wire [GKIS_NSRC-1:0] wait_rel;

    generate
        for (g = 0; g < GKIS_NCH; g++) begin : g_sel
            // code zero or an unused code leaves the channel quiet
            wire raw = pick_pin(pin_code_ff[g], pins_flat);
            // a channel without a pin stays quiet whatever its polarity
            assign active[g] = code_valid(pin_code_ff[g])
                               & (raw ^ pol_ff[GKIS_POL_LSB + g]);
            assign filt_on[g] = filt_ff[GKIS_FILT_ON_LSB + g];
            assign wait_rel[g] = pol_ff[GKIS_WAIT_LSB + g];
        end
    endgenerate

    // keypad: any enabled pin at its active level
    assign active[GKIS_KEY] = |(key_en & (key_pins ^ {32{key_low}}));
    assign filt_on[GKIS_KEY] = filt_ff[GKIS_FILT_KEY_BIT];
    assign wait_rel[GKIS_KEY] = 1'b0;

    //------------------------------------------------------------------
    // per-source filter, pending and release logic
    //------------------------------------------------------------------
    wire [5:0] filt_ms = filt_ff[5:0];
    wire [GKIS_NSRC-1:0] set_pend;

    generate
        for (g = 0; g < GKIS_NSRC; g++) begin : g_src
            logic [5:0] ms_cnt_ff;
            wire held = ms_cnt_ff >= filt_ms;
            wire qual = active[g] & (~filt_on[g] | held);
            wire hold_off = block_ff[g] | (clr_req[g] & wait_rel[g]);
            assign set_pend[g] = qual & ~hold_off;

            // count whole ticks while the input stays active
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    ms_cnt_ff <= GKIS_RST6;
                end else if (!active[g] || !filt_on[g]) begin
                    ms_cnt_ff <= GKIS_RST6;
                end else if (tick_ff && !held) begin
                    ms_cnt_ff <= ms_cnt_ff + 6'h01;
                end
            end

            // pending: set wins over a clear in the same cycle unless the channel waits for release
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    pend_ff[g] <= 1'b0;
                end else begin
                    pend_ff[g] <= (pend_ff[g] & ~clr_req[g]) | set_pend[g];
                end
            end

            // after a clear on a channel that waits for release, hold off until the input goes inactive
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    block_ff[g] <= 1'b0;
                end else if (clr_req[g] && wait_rel[g] && active[g]) begin
                    block_ff[g] <= 1'b1;
                end else if (!active[g] || !wait_rel[g]) begin
                    block_ff[g] <= 1'b0;
                end
            end
        end
    endgenerate

    //------------------------------------------------------------------
    // sticky status and interrupt output
    //------------------------------------------------------------------
    wire [GKIS_NSRC-1:0] rise = set_pend & ~pend_ff;
    wire [GKIS_NSRC-1:0] nxt_stat = (stat_ff & ~stat_rdclr) | rise;

    // status set wins over read clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stat_ff <= GKIS_RST6;
            irq_ff <= 1'b0;
        end else begin
            stat_ff <= nxt_stat;
            irq_ff <= |(nxt_stat & mask_ff);
        end
    end

    //------------------------------------------------------------------
    // outputs
    //------------------------------------------------------------------
    assign prdata = rdata_ff;
    assign pready = ready_ff;
    assign pslverr = err_ff;
    assign pin_irq_chan0 = pend_ff[0];
    assign pin_irq_chan1 = pend_ff[1];
    assign pin_irq_chan2 = pend_ff[2];
    assign pin_irq_chan3 = pend_ff[3];
    assign pin_irq_chan4 = pend_ff[4];
    assign keypad_irq_line = pend_ff[GKIS_KEY];
    assign irq = irq_ff;

endmodule
`default_nettype wire

/* dv/gkis_top_sva.sv */
`timescale 1ns/100ps
`default_nettype none
//------------------------------------------------------------------
// port checker for the pin interrupt selector
//------------------------------------------------------------------
module gkis_chk
    import gkis_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [GKIS_AW-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic pin_irq_chan0,
    input wire logic pin_irq_chan4,
    input wire logic keypad_irq_line
);
    logic clr_wr;
    // write access to the clear register
    assign clr_wr = psel && penable && pwrite && (paddr == GKIS_A_CLR);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // pending only drops on a clear write of its own bit
    property p_hold(pend, k);
        pend && !(clr_wr && pwdata[k]) |=> pend;
    endproperty
    a_ready_follows: assert property (psel && !penable |=> pready)
        else $error("no ready after setup");
    a_ready_single: assert property ($rose(pready) |=> $fell(pready))
        else $error("ready held too long");
    a_err_with_ready: assert property (pslverr |-> pready)
        else $error("error without ready");
    a_idle_data_zero: assert property (!pready |-> prdata == 32'h0)
        else $error("read data outside access");
    a_upper_zero: assert property (prdata[31:16] == 16'h0)
        else $error("upper read data not zero");
    a_clear_reads: assert property (
        pready && !pwrite && paddr == GKIS_A_CLR |-> prdata == 32'h0)
        else $error("clear register read not zero");
    a_hold_chan0: assert property (p_hold(pin_irq_chan0, 0))
        else $error("channel 0 pending lost");
    a_hold_chan4: assert property (p_hold(pin_irq_chan4, 4))
        else $error("channel 4 pending lost");
    a_hold_keypad: assert property (p_hold(keypad_irq_line, 5))
        else $error("keypad pending lost");
    c_chan0: cover property ($rose(pin_irq_chan0));
    c_keypad: cover property ($rose(keypad_irq_line));
    c_error: cover property (pslverr);
endmodule
bind gkis_top gkis_chk i_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pin_irq_chan0(pin_irq_chan0), .pin_irq_chan4(pin_irq_chan4),
    .keypad_irq_line(keypad_irq_line));
`default_nettype wire

/* dv/gkis_pin_model.sv */
`timescale 1ns/100ps
`default_nettype none
//------------------------------------------------------------------
// keys and signals on the port pins
//------------------------------------------------------------------
module gkis_pin_model (
    input wire logic pclk,
    output logic [7:0] port0_pins,
    output logic [5:0] port1_pins,
    output logic [9:0] port2_pins,
    output logic [7:0] port3_pins
);
    logic [31:0] lvl_ff;
    // pin levels, port 0 in the low bits
    assign {port3_pins, port2_pins, port1_pins, port0_pins} = lvl_ff;
    initial lvl_ff = 32'h0;
    // new levels land after dly idle cycles, just after an edge
    task automatic drive(input logic [31:0] v, input int dly);
        repeat (dly) @(posedge pclk);
        @(posedge pclk);
        lvl_ff <= v;
    endtask
endmodule
`default_nettype wire

/* dv/tb_gkis_top.sv */
`timescale 1ns/100ps
`default_nettype none
module tb_gkis_top
    import gkis_pkg::*;
;
    localparam int TICK = 8;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err, mapped;
    logic [7:0] paddr, p0, p3;
    logic [5:0] p1;
    logic [9:0] p2;
    logic [31:0] pwdata, prdata, rd;
    logic [6:0] irqs;
    logic [7:0] ta [5];
    logic [15:0] te [5];
    int failures, samples_checked;

    gkis_top #(.TICK_CYCLES(TICK)) i_gkis_top (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .port0_pins(p0), .port1_pins(p1),
        .port2_pins(p2), .port3_pins(p3), .pin_irq_chan0(irqs[0]), .pin_irq_chan1(irqs[1]),
        .pin_irq_chan2(irqs[2]), .pin_irq_chan3(irqs[3]), .pin_irq_chan4(irqs[4]),
        .keypad_irq_line(irqs[5]), .irq(irqs[6]));
    gkis_pin_model i_gkis_pin_model (.pclk(pclk), .port0_pins(p0), .port1_pins(p1),
        .port2_pins(p2), .port3_pins(p3));

    // 40 MHz clock
    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end
    //------------------------------------------------------------------
    // tasks
    //------------------------------------------------------------------
    task automatic final_report();
        $display("counts: %0d checked, %0d failed", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            failures++;
            $display("FAIL %s expected %h seen %h", what, exp, got);
        end
    endtask
    // one apb transfer, held until pready is sampled high
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        chk("ready", 32'h1, {31'h0, pready});
        if (pready !== 1'b1) final_report();
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rdc(input string what, input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(what, exp, rd);
    endtask
    task automatic wait_irq(input int b, input logic v, input int lim);
        int n;
        n = 0;
        while (irqs[b] !== v && n < lim) begin
            @(posedge pclk);
            n++;
        end
        chk("irq line", {31'h0, v}, {31'h0, irqs[b]});
        if (irqs[b] !== v) final_report();
    endtask
    task automatic quiet(input int b, input int cyc);
        repeat (cyc) @(posedge pclk);
        chk("quiet line", 32'h0, {31'h0, irqs[b]});
    endtask
    //------------------------------------------------------------------
    // main sequence
    //------------------------------------------------------------------
    initial begin
        int k;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        failures = 0;
        samples_checked = 0;
        ta = '{GKIS_A_SEL0, GKIS_A_FILT, GKIS_A_POL, GKIS_A_CLR, GKIS_A_KEYHI};
        te = '{16'h003F, 16'h3F3F, 16'h1F1F, 16'h0000, 16'h00FF};
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        // reset values and the unmapped holes
        for (int a = 0; a <= 8'h64; a += 4) begin
            apb(1'b0, 8'(a), 32'h0);
            mapped = ((a % 8 == 0) && a <= 8'h58 && a != 8'h28) || a >= 8'h60;
            chk("reset read", 32'h0, rd);
            chk("slave error", {31'h0, !mapped}, {31'h0, err});
        end
        for (int i = 0; i < 5; i++) begin
            wr(ta[i], 32'hFFFFFFFF);
            rdc("field mask", ta[i], {16'h0, te[i]});
            wr(ta[i], 32'h0);
        end
        $display("test registers done");
        // codes 1..31 each to its own pin, code 0 to none, spread over all five channels
        for (int c = 0; c < 32; c++) begin
            k = c % 5;
            wr(GKIS_A_STEP * 8'(k), 32'(c));
            i_gkis_pin_model.drive(c == 0 ? 32'hFFFFFFFF : ~(32'h1 << (c - 1)), 0);
            quiet(k, 6);
            if (c != 0) begin
                i_gkis_pin_model.drive(32'h1 << (c - 1), 0);
                wait_irq(k, 1'b1, 10);
                i_gkis_pin_model.drive(32'h0, 0);
                wr(GKIS_A_CLR, 32'h0);
                chk("held pending", 32'h1, {31'h0, irqs[k]});
                wr(GKIS_A_CLR, 32'h1 << k);
                wait_irq(k, 1'b0, 10);
            end else begin
                i_gkis_pin_model.drive(32'h0, 0);
            end
            // park the channel so it cannot fire during later codes
            wr(GKIS_A_STEP * 8'(k), 32'h0);
        end
        for (int i = 1; i < 5; i++) wr(GKIS_A_STEP * 8'(i), 32'h0);
        wr(GKIS_A_SEL0, 32'h1);
        $display("test routing done");
        // active low with release wait on channel 0
        wr(GKIS_A_POL, 32'h0101);
        wait_irq(0, 1'b1, 10);
        wr(GKIS_A_CLR, 32'h1);
        quiet(0, 6);
        i_gkis_pin_model.drive(32'h1, 0);
        quiet(0, 4);
        i_gkis_pin_model.drive(32'h0, 0);
        wait_irq(0, 1'b1, 10);
        wr(GKIS_A_POL, 32'h0001);
        wr(GKIS_A_CLR, 32'h1);
        wait_irq(0, 1'b1, 10);
        wr(GKIS_A_POL, 32'h0);
        wr(GKIS_A_CLR, 32'h1);
        wait_irq(0, 1'b0, 10);
        $display("test polarity done");
        // filter on channel 0 and on the keypad, two ticks each
        wr(GKIS_A_FILT, 32'h0102);
        i_gkis_pin_model.drive(32'h1, 0);
        i_gkis_pin_model.drive(32'h0, 2);
        quiet(0, 12);
        i_gkis_pin_model.drive(32'h1, 0);
        quiet(0, 4);
        wait_irq(0, 1'b1, 30);
        wr(GKIS_A_FILT, 32'h2002);
        wr(GKIS_A_KEYLO, 32'h1);
        quiet(5, 4);
        wait_irq(5, 1'b1, 30);
        i_gkis_pin_model.drive(32'h0, 0);
        wr(GKIS_A_CLR, 32'h21);
        wait_irq(5, 1'b0, 10);
        wr(GKIS_A_KEYLO, 32'h0);
        wr(GKIS_A_FILT, 32'h0);
        $display("test filter done");
        // status, mask and the summary line
        apb(1'b0, GKIS_A_STAT, 32'h0);
        wr(GKIS_A_MASK, 32'h1);
        i_gkis_pin_model.drive(32'h1, 0);
        wait_irq(6, 1'b1, 10);
        i_gkis_pin_model.drive(32'h0, 0);
        wr(GKIS_A_CLR, 32'h1);
        rdc("status", GKIS_A_STAT, 32'h1);
        wait_irq(6, 1'b0, 10);
        wr(GKIS_A_MASK, 32'h0);
        i_gkis_pin_model.drive(32'h1, 0);
        quiet(6, 6);
        rdc("masked status", GKIS_A_STAT, 32'h1);
        $display("test interrupt done");
        final_report();
    end
endmodule
`default_nettype wire
